// *** verilog/rac_consts.svh ***
// Constants of the alarm and trim block: field positions, reset values, timing.
// Assumes inclusion by bare name from design files.
`ifndef RAC_CONSTS_SVH
`define RAC_CONSTS_SVH
// ----------------------------------------
// Alarm configuration fields
// ----------------------------------------
`define RAC_CFG_ON_BIT 15
`define RAC_CFG_ENDLESS_BIT 14
`define RAC_CFG_SEL_HI 13
`define RAC_CFG_SEL_LO 10
`define RAC_CFG_RPT_HI 7
`define RAC_CFG_RPT_LO 0
`define RAC_CFG_RST 16'h0000
`define RAC_RPT_MAX 8'hff
`define RAC_RPT_ZERO 8'h00
// ----------------------------------------
// Trim
// ----------------------------------------
`define RAC_TRIM_RST 8'h00
`define RAC_TRIM_STEP 4
`define RAC_HALF_SEC_PER_MIN 120
`endif

// *** verilog/rac_pkg.sv ***
// Types of the alarm and trim block.
// Assumes no surroundings beyond the consts header.
package rac_pkg;
  // Digit set of the current time or of the alarm value
  typedef struct packed {
    logic [4:0] month;
    logic [5:0] day;
    logic [2:0] wday;
    logic [5:0] hour;
    logic [6:0] min;
    logic [6:0] sec;
  } rac_time_t;
  // Alarm configuration word
  typedef struct packed {
    logic on;
    logic endless;
    logic [3:0] digit_select;
    logic [1:0] unused;
    logic [7:0] repeat_count;
  } rac_cfg_t;
  typedef enum logic [2:0] {
    RAC_IDLE = 3'b001,
    RAC_ADD = 3'b010,
    RAC_DROP = 3'b100
  } rac_trim_st_t;
endpackage : rac_pkg

// *** verilog/rac_match.sv ***
// Masked comparator of alarm value digits against the current time.
// Assumes both digit sets are stable on the clock of the caller.
`timescale 1ns/1ps
`default_nettype none
module rac_match (
  // Inputs
  input wire logic [3:0] i_digit_select,
  input wire rac_pkg::rac_time_t i_now,
  input wire rac_pkg::rac_time_t i_alarm,
  input wire logic i_half_phase,
  // Result
  output logic o_match
);
  wire eq_sec_one = i_now.sec[3:0] == i_alarm.sec[3:0];
  wire eq_sec = i_now.sec == i_alarm.sec;
  wire eq_min_one = eq_sec && i_now.min[3:0] == i_alarm.min[3:0];
  wire eq_min = eq_sec && i_now.min == i_alarm.min;
  wire eq_hour = eq_min && i_now.hour == i_alarm.hour;
  wire eq_wday = eq_hour && i_now.wday == i_alarm.wday;
  wire eq_day = eq_hour && i_now.day == i_alarm.day;
  wire eq_year = eq_day && i_now.month == i_alarm.month;
  // Interval per digit select code; half second fires on every tick
  assign o_match = (i_digit_select == 4'h0) ? 1'b1 :
                   (i_digit_select == 4'h1) ? i_half_phase :
                   (i_digit_select == 4'h2) ? i_half_phase && eq_sec_one :
                   (i_digit_select == 4'h3) ? i_half_phase && eq_sec :
                   (i_digit_select == 4'h4) ? i_half_phase && eq_min_one :
                   (i_digit_select == 4'h5) ? i_half_phase && eq_min :
                   (i_digit_select == 4'h6) ? i_half_phase && eq_hour :
                   (i_digit_select == 4'h7) ? i_half_phase && eq_wday :
                   (i_digit_select == 4'h8) ? i_half_phase && eq_day :
                   (i_digit_select == 4'h9) ? i_half_phase && eq_year : 1'b0;
endmodule : rac_match
`default_nettype wire

// *** verilog/rac_alarm_trim.sv ***
// Alarm sequencer and once-per-minute timebase trim of a clock calendar core.
// Assumes time digits and the half-second tick come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "rac_consts.svh"
module rac_alarm_trim (
  // Clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  // Timebase
  input wire logic i_half_tick,
  input wire logic i_second_phase,
  input wire logic i_minute_tick,
  input wire rac_pkg::rac_time_t i_now,
  // Software control
  input wire logic [7:0] i_trim,
  input wire logic i_cfg_we,
  input wire rac_pkg::rac_cfg_t i_cfg_wdata,
  input wire rac_pkg::rac_time_t i_alarm_value,
  // Outputs
  output logic o_pulse_add,
  output logic o_pulse_drop,
  output rac_pkg::rac_cfg_t o_cfg,
  output logic o_alarm_irq,
  output logic o_alarm_pulse
);
  // ----------------------------------------
  // Trim sequencer
  // ----------------------------------------
  rac_pkg::rac_trim_st_t trim_st;
  rac_pkg::rac_trim_st_t next_trim_st;
  logic [9:0] trim_left;
  logic [9:0] next_trim_left;
  wire trim_neg = i_trim[7];
  wire [7:0] trim_mag = trim_neg ? 8'(~i_trim + 8'h01) : i_trim;
  wire [9:0] trim_pulses = {trim_mag, 2'b00};
  wire trim_start = i_minute_tick && (i_trim != `RAC_TRIM_RST);
  always_comb begin
    next_trim_st = trim_st;
    next_trim_left = trim_left;
    unique case (trim_st)
      rac_pkg::RAC_IDLE: begin
        if (trim_start) begin
          next_trim_left = trim_pulses;
          next_trim_st = trim_neg ? rac_pkg::RAC_DROP : rac_pkg::RAC_ADD;
        end
      end
      rac_pkg::RAC_ADD, rac_pkg::RAC_DROP: begin
        next_trim_left = trim_left - 10'h001;
        if (trim_left == 10'h001) begin
          next_trim_st = rac_pkg::RAC_IDLE;
        end
      end
      default: begin
        next_trim_st = rac_pkg::RAC_IDLE;
      end
    endcase
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      trim_st <= rac_pkg::RAC_IDLE;
      trim_left <= 10'h000;
      o_pulse_add <= 1'b0;
      o_pulse_drop <= 1'b0;
    end else if (i_ce) begin
      trim_st <= next_trim_st;
      trim_left <= next_trim_left;
      o_pulse_add <= next_trim_st == rac_pkg::RAC_ADD;
      o_pulse_drop <= next_trim_st == rac_pkg::RAC_DROP;
    end
  end
  // ----------------------------------------
  // Alarm sequencer
  // ----------------------------------------
  logic match;
  rac_match u_match (
    .i_digit_select(o_cfg.digit_select),
    .i_now(i_now),
    .i_alarm(i_alarm_value),
    .i_half_phase(i_second_phase),
    .o_match(match)
  );
  wire fire = o_cfg.on && i_half_tick && match;
  wire at_zero = o_cfg.repeat_count == `RAC_RPT_ZERO;
  wire last_alarm = at_zero && !o_cfg.endless;
  rac_pkg::rac_cfg_t next_cfg;
  always_comb begin
    next_cfg = o_cfg;
    if (i_cfg_we) begin
      next_cfg = i_cfg_wdata;
      next_cfg.unused = 2'b00;
    end
    if (fire) begin
      next_cfg.repeat_count = o_cfg.repeat_count - 8'h01;
      if (last_alarm) begin
        next_cfg.repeat_count = `RAC_RPT_ZERO;
        next_cfg.on = 1'b0;
      end
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_cfg <= `RAC_CFG_RST;
      o_alarm_irq <= 1'b0;
      o_alarm_pulse <= 1'b0;
    end else if (i_ce) begin
      o_cfg <= next_cfg;
      o_alarm_irq <= fire;
      o_alarm_pulse <= o_alarm_pulse ^ fire;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_irq_follows_fire: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    i_ce && fire |=> o_alarm_irq) else $error("alarm without interrupt");
  a_pulse_toggle: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    i_ce && fire |=> o_alarm_pulse != $past(o_alarm_pulse)) else $error("alarm pulse did not toggle");
  a_pulse_hold: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    !fire |=> $stable(o_alarm_pulse)) else $error("alarm pulse moved without alarm");
  a_final_clears_on: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    i_ce && fire && last_alarm && !i_cfg_we |=> !o_cfg.on) else $error("final alarm left enable set");
  a_count_decrements: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    i_ce && fire && !at_zero && !i_cfg_we |=> o_cfg.repeat_count == $past(o_cfg.repeat_count) - 8'h01)
    else $error("repeat count not decremented");
  a_endless_wraps: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    i_ce && fire && at_zero && o_cfg.endless && !i_cfg_we |=> o_cfg.on && o_cfg.repeat_count == `RAC_RPT_MAX)
    else $error("endless repeat did not wrap");
  a_no_fire_off: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    i_ce && !o_cfg.on |=> !o_alarm_irq) else $error("alarm while disabled");
  a_trim_count: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    i_ce && trim_st == rac_pkg::RAC_IDLE && trim_start |=> trim_left == $past(trim_pulses))
    else $error("trim pulse count wrong");
  a_trim_sign: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    i_ce && trim_st == rac_pkg::RAC_IDLE && trim_start && trim_neg |=> trim_st == rac_pkg::RAC_DROP)
    else $error("negative trim did not drop");
  a_trim_excl: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    !(o_pulse_add && o_pulse_drop)) else $error("add and drop together");
  a_trim_add_sign: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    i_ce && trim_st == rac_pkg::RAC_IDLE && trim_start && !trim_neg |=> trim_st == rac_pkg::RAC_ADD)
    else $error("positive trim did not add");
  a_trim_ends: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    i_ce && trim_st != rac_pkg::RAC_IDLE && trim_left == 10'h001 |=> !o_pulse_add && !o_pulse_drop)
    else $error("trim burst did not end");
  a_irq_one_cycle: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    i_ce && o_alarm_irq && !fire |=> !o_alarm_irq) else $error("interrupt held too long");
  a_single_shot: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    i_ce && fire && at_zero && !o_cfg.endless && !i_cfg_we |=> o_cfg.repeat_count == 8'h00)
    else $error("single alarm left a count");
  a_off_codes: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    i_ce && o_cfg.digit_select > 4'h9 |=> !o_alarm_irq) else $error("alarm on unused select code");
  a_sec_mismatch: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    i_ce && i_half_tick && o_cfg.digit_select == 4'h3 && i_now.sec != i_alarm_value.sec |=> !o_alarm_irq)
    else $error("alarm with seconds unequal");
  a_cfg_load: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    i_ce && i_cfg_we && !fire |=> o_cfg.digit_select == $past(i_cfg_wdata.digit_select) &&
    o_cfg.repeat_count == $past(i_cfg_wdata.repeat_count)) else $error("config write not loaded");
  // ----------------------------------------
  // Trim burst length watch
  // ----------------------------------------
  // Counts back-to-back correction pulses; a burst may never exceed four times the largest trim
  logic [9:0] burst_len;
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      burst_len <= 10'h000;
    end else if (i_ce) begin
      if (o_pulse_add || o_pulse_drop) begin
        burst_len <= burst_len + 10'h001;
      end else begin
        burst_len <= 10'h000;
      end
    end
  end
  a_burst_bound: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    burst_len <= 10'h200) else $error("trim burst too long");
  c_single: cover property (@(posedge i_clk_sys) fire && last_alarm);
  c_endless: cover property (@(posedge i_clk_sys) fire && at_zero && o_cfg.endless);
  c_trim_add: cover property (@(posedge i_clk_sys) o_pulse_add);
  c_trim_drop: cover property (@(posedge i_clk_sys) o_pulse_drop);
endmodule : rac_alarm_trim
`default_nettype wire

// *** bench/rac_alarm_trim_test.sv ***
// Self-checking bench of the alarm sequencer and once-per-minute timebase trim.
// Assumes the package and design files are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module rac_alarm_trim_test;
  logic i_clk_sys = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_ce = 1'b1;
  logic i_half_tick = 1'b0;
  logic i_second_phase = 1'b1;
  logic i_minute_tick = 1'b0;
  rac_pkg::rac_time_t i_now = '0;
  logic [7:0] i_trim = 8'h00;
  logic i_cfg_we = 1'b0;
  rac_pkg::rac_cfg_t i_cfg_wdata = '0;
  rac_pkg::rac_time_t i_alarm_value = '0;
  logic o_pulse_add;
  logic o_pulse_drop;
  logic o_alarm_irq;
  logic o_alarm_pulse;
  rac_pkg::rac_cfg_t o_cfg;
  int n_fail = 0;
  int compares = 0;
  int cycles = 0;
  logic [15:0] seed = 16'hcf24;
  rac_alarm_trim i_dut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_half_tick(i_half_tick),
    .i_second_phase(i_second_phase), .i_minute_tick(i_minute_tick), .i_now(i_now), .i_trim(i_trim),
    .i_cfg_we(i_cfg_we), .i_cfg_wdata(i_cfg_wdata), .i_alarm_value(i_alarm_value), .o_pulse_add(o_pulse_add),
    .o_pulse_drop(o_pulse_drop), .o_cfg(o_cfg), .o_alarm_irq(o_alarm_irq), .o_alarm_pulse(o_alarm_pulse));
  always #10 i_clk_sys = ~i_clk_sys;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // Pulses per minute expected for a trim word: four per step, direction from sign
  function automatic logic [15:0] exp_count(input logic [7:0] t, input logic neg);
    return (t[7] == neg) ? 16'(4 * (t[7] ? 256 - int'(t) : int'(t))) : 16'h0000;
  endfunction : exp_count
  task automatic report_and_stop();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic write_cfg(input logic on, input logic endl, input logic [3:0] sel, input logic [7:0] rpt);
    @(posedge i_clk_sys);
    i_cfg_wdata <= {on, endl, sel, 2'b00, rpt};
    i_cfg_we <= 1'b1;
    @(posedge i_clk_sys);
    i_cfg_we <= 1'b0;
    @(posedge i_clk_sys);
    #1;
    chk("cfg", {on, endl, sel, 2'b00, rpt}, o_cfg);
  endtask : write_cfg
  task automatic half_ticks(input int n, output int irqs);
    irqs = 0;
    repeat (n) begin
      @(posedge i_clk_sys);
      i_half_tick <= 1'b1;
      @(posedge i_clk_sys);
      i_half_tick <= 1'b0;
      repeat (3) begin
        #1;
        if (o_alarm_irq === 1'b1) irqs++;
        @(posedge i_clk_sys);
      end
    end
  endtask : half_ticks
  task automatic trim_run(input logic [7:0] t);
    int adds;
    int drops;
    adds = 0;
    drops = 0;
    @(posedge i_clk_sys);
    i_trim <= t;
    @(posedge i_clk_sys);
    i_minute_tick <= 1'b1;
    @(posedge i_clk_sys);
    i_minute_tick <= 1'b0;
    repeat (int'(exp_count(t, 1'b0) + exp_count(t, 1'b1)) + 4) begin
      #1;
      if (o_pulse_add === 1'b1) adds++;
      if (o_pulse_drop === 1'b1) drops++;
      @(posedge i_clk_sys);
    end
    chk("adds", exp_count(t, 1'b0), 16'(adds));
    chk("drops", exp_count(t, 1'b1), 16'(drops));
  endtask : trim_run
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    int irqs;
    logic p0;
    repeat (5) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    #1;
    chk("cfg_reset", 16'h0000, o_cfg);
    chk("outs_reset", 16'h0000, 16'({o_pulse_add, o_pulse_drop, o_alarm_irq, o_alarm_pulse}));
    trim_run(8'h01);
    trim_run(8'hfe);
    trim_run(8'h80);
    trim_run(8'h7f);
    trim_run(8'h00);
    repeat (3) begin
      seed = lfsr(seed);
      trim_run(seed[7:0]);
    end
    $display("test trim done");
    p0 = o_alarm_pulse;
    write_cfg(1'b1, 1'b0, 4'h0, 8'h00);
    half_ticks(2, irqs);
    chk("single_irqs", 16'd1, 16'(irqs));
    chk("single_cfg", 16'h0000, o_cfg);
    chk("pulse_toggle", {15'h0, ~p0}, {15'h0, o_alarm_pulse});
    write_cfg(1'b1, 1'b0, 4'h0, 8'h02);
    half_ticks(5, irqs);
    chk("repeat_irqs", 16'd3, 16'(irqs));
    chk("repeat_cfg", 16'h0000, o_cfg);
    chk("pulse_odd", {15'h0, p0}, {15'h0, o_alarm_pulse});
    write_cfg(1'b1, 1'b0, 4'h0, 8'hff);
    half_ticks(3, irqs);
    chk("max_cfg", 16'h80fc, o_cfg);
    write_cfg(1'b1, 1'b1, 4'h0, 8'h00);
    half_ticks(2, irqs);
    chk("endless_irqs", 16'd2, 16'(irqs));
    chk("endless_cfg", 16'hc0fe, o_cfg);
    $display("test repeat done");
    write_cfg(1'b0, 1'b0, 4'h0, 8'h00);
    @(posedge i_clk_sys);
    i_alarm_value.sec <= 7'h25;
    i_now.sec <= 7'h24;
    write_cfg(1'b1, 1'b0, 4'h3, 8'h00);
    half_ticks(2, irqs);
    chk("sec_miss", 16'd0, 16'(irqs));
    i_now.sec <= 7'h25;
    i_ce <= 1'b0;
    half_ticks(1, irqs);
    chk("ce_frozen", 16'd0, 16'(irqs));
    i_ce <= 1'b1;
    half_ticks(1, irqs);
    chk("sec_hit", 16'd1, 16'(irqs));
    i_second_phase <= 1'b0;
    write_cfg(1'b1, 1'b0, 4'h1, 8'h00);
    half_ticks(1, irqs);
    chk("half_phase", 16'd0, 16'(irqs));
    for (int code = 0; code < 10; code++) begin
      write_cfg(1'b0, 1'b0, 4'h0, 8'h00);
      @(posedge i_clk_sys);
      seed = lfsr(seed);
      i_now <= {seed, seed, seed[1:0]};
      i_alarm_value <= {seed, seed, seed[1:0]};
      i_second_phase <= 1'b1;
      write_cfg(1'b1, 1'b0, 4'(code), 8'h00);
      half_ticks(1, irqs);
      chk("code_hit", 16'd1, 16'(irqs));
    end
    write_cfg(1'b0, 1'b0, 4'h0, 8'h00);
    @(posedge i_clk_sys);
    i_now.sec <= 7'h15;
    i_alarm_value.sec <= 7'h25;
    write_cfg(1'b1, 1'b0, 4'h2, 8'h00);
    half_ticks(1, irqs);
    chk("ones_hit", 16'd1, 16'(irqs));
    write_cfg(1'b1, 1'b0, 4'ha, 8'h00);
    half_ticks(2, irqs);
    chk("code_off", 16'd0, 16'(irqs));
    $display("test match done");
    report_and_stop();
  end
endmodule : rac_alarm_trim_test
`default_nettype wire
